// ===== logic/board_irq_pkg.sv
package board_irq_pkg;
  // board generations
  localparam int VARIANT_FIRST = 0;
  localparam int VARIANT_LATER = 1;
  localparam int VARIANT_NEWEST = 2;

  // link register indices
  localparam logic [2:0] IDX_SITE_RESET = 3'h0;
  localparam logic [2:0] IDX_SEL_BASE = 3'h1;
  localparam int NUM_CH = 5;
  localparam logic [2:0] IDX_SEL_LAST = 3'h5;

  // channel order: nmi, ext four .. ext seven
  localparam int CH_NMI = 0;
  localparam int CH_FOUR = 1;
  localparam int CH_FIVE = 2;
  localparam int CH_SIX = 3;

  // site reset control fields
  localparam int BIT_PARALLEL_RESET = 0;
  localparam int BIT_SERIAL_RESET = 1;
  localparam int BIT_EXTENDER_RESET = 2;
  localparam logic [3:0] SITE_RESET_INIT = 4'h0;
  localparam logic [3:0] SITE_MASK_FIRST = 4'h3;
  localparam logic [3:0] SITE_MASK_LATER = 4'h7;

  // selector layout and reset values
  localparam logic [3:0] SEL_MASK_FIRST = 4'h3;
  localparam logic [3:0] SEL_MASK_LATER = 4'hF;
  localparam logic [3:0] SEL_INIT [NUM_CH] = '{4'hF, 4'h4, 4'h5, 4'h0, 4'h2};

  // selector codes
  localparam logic [3:0] CODE_SHARED2 = 4'h0;
  localparam logic [3:0] CODE_SERIAL_CTRL = 4'h2;
  localparam logic [3:0] CODE_USB = 4'h3;
  localparam logic [3:0] CODE_SERIAL_SITE0 = 4'h4;
  localparam logic [3:0] CODE_SERIAL_SITE1 = 4'h5;
  localparam logic [3:0] CODE_PARALLEL0 = 4'h8;
  localparam logic [3:0] CODE_PARALLEL1 = 4'h9;
  localparam logic [3:0] CODE_PARALLEL2 = 4'hA;
  localparam logic [3:0] CODE_PARALLEL3 = 4'hB;
  localparam logic [3:0] CODE_WATCHDOG = 4'hC;
  localparam logic [3:0] CODE_CLOCK_WDT = 4'hD;
  localparam logic [3:0] CODE_CLOCK_ALARM = 4'hE;

  // a request must stay active longer than two dsp clock periods
  localparam int MIN_HOLD_CYCLES = 3;
  localparam logic [1:0] HOLD_EXTRA = 2'(MIN_HOLD_CYCLES - 1);

  // host register byte offsets and fields
  localparam logic [7:0] ADDR_LINK_CMD = 8'h00;
  localparam logic [7:0] ADDR_LINK_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0] ADDR_POLARITY = 8'h10;
  localparam logic [7:0] ADDR_LEVEL = 8'h14;
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_DATA_LSB = 4;
  localparam int CMD_WRITE_BIT = 8;
  localparam int STATUS_BUSY_BIT = 8;
  localparam logic [3:0] POLARITY_INIT = 4'h0;
  localparam logic [4:0] IRQ_INIT = 5'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [2:0] {
    LINK_IDLE = 3'b001,
    LINK_ISSUE = 3'b010,
    LINK_WAIT = 3'b100
  } link_state_e;
endpackage

// ===== logic/board_link_if.sv
interface board_link_if;
  logic link_req;
  logic link_write;
  logic [2:0] link_addr;
  logic [3:0] link_wdata;
  logic link_ack;
  logic [3:0] link_rdata;
  logic dsp_nmi;
  logic dsp_ext_irq_four;
  logic dsp_ext_irq_five;
  logic dsp_ext_irq_six;
  logic dsp_ext_irq_seven;

  modport board (
    input link_req,
    input link_write,
    input link_addr,
    input link_wdata,
    output link_ack,
    output link_rdata,
    output dsp_nmi,
    output dsp_ext_irq_four,
    output dsp_ext_irq_five,
    output dsp_ext_irq_six,
    output dsp_ext_irq_seven
  );

  modport dsp (
    output link_req,
    output link_write,
    output link_addr,
    output link_wdata,
    input link_ack,
    input link_rdata,
    input dsp_nmi,
    input dsp_ext_irq_four,
    input dsp_ext_irq_five,
    input dsp_ext_irq_six,
    input dsp_ext_irq_seven
  );
endinterface

// ===== logic/irq_hold.sv
module irq_hold #(
  parameter logic IDLE_LEVEL = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic request,
  output logic pin
);
  logic [1:0] hold;
  logic active;

  assign active = request | (hold != 2'h0);

  // short source pulses are stretched so the dsp cannot miss them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold <= 2'h0;
    end else if (request) begin
      hold <= board_irq_pkg::HOLD_EXTRA;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin <= IDLE_LEVEL;
    end else begin
      pin <= active ? ~IDLE_LEVEL : IDLE_LEVEL;
    end
  end
endmodule

// ===== logic/board_irq_router_site_reset.sv
// What this block does
// - parallel site reset bit: 0 resets
// - one bit resets both serial sites
// - extender reset bit on later boards only
// - first gen: four wired to request 0
// - first gen: five wired to request 1
// - first gen: six, seven use 2-bit selectors
// - later: five 4-bit source selectors
// - later source set; newest adds clock chip
// - first gen ext requests are active low
// - first gen software sets polarity 0xF
// - later requests active high, polarity zero
// - requests stay active over two clocks
// - serial and usb interrupts active low
// - clock chip outputs active low, continuous
// - fixed 4-bit selector code map
// - selector reset values per channel
// - reserved codes connect no source
module board_irq_router_site_reset #(
  parameter int BOARD_VARIANT = board_irq_pkg::VARIANT_NEWEST
) (
  input wire logic hclk,
  input wire logic hresetn,
  board_link_if.board link,
  input wire logic [2:0] shared_request,
  input wire logic [2:0] serial_site_request,
  input wire logic [3:0] parallel_site_request,
  input wire logic serial_ctrl_irq_n,
  input wire logic usb_ctrl_irq_n,
  input wire logic watchdog_expiry_request,
  input wire logic clock_chip_out_first_n,
  input wire logic clock_chip_out_second_n,
  output logic parallel_site_reset_n,
  output logic serial_sites_reset_n,
  output logic extender_reset_n
);
  localparam bit FIRST = (BOARD_VARIANT == board_irq_pkg::VARIANT_FIRST);
  localparam bit NEWEST = (BOARD_VARIANT == board_irq_pkg::VARIANT_NEWEST);
  localparam logic [3:0] SITE_MASK =
    FIRST ? board_irq_pkg::SITE_MASK_FIRST : board_irq_pkg::SITE_MASK_LATER;

  logic [3:0] site_reset_control;
  logic [3:0] source_select [board_irq_pkg::NUM_CH];
  logic [15:0] src_later;
  logic [3:0] src_first;
  logic [board_irq_pkg::NUM_CH-1:0] route;
  logic [board_irq_pkg::NUM_CH-1:0] irq_pin;
  logic wr;

  assign wr = link.link_req & link.link_write;

  // absent selectors read zero and ignore writes
  function automatic logic [3:0] sel_mask(input int ch);
    if (!FIRST) begin
      return board_irq_pkg::SEL_MASK_LATER;
    end else if (ch >= board_irq_pkg::CH_SIX) begin
      return board_irq_pkg::SEL_MASK_FIRST;
    end
    return 4'h0;
  endfunction

  // unlisted codes have no source bit set, so they route nothing
  function automatic logic pick(input logic [3:0] code, input logic [15:0] vec);
    return vec[code];
  endfunction

  // selector ch sits at link index base + ch
  function automatic logic sel_hit(input logic [2:0] addr, input int ch);
    return addr == board_irq_pkg::IDX_SEL_BASE + 3'(ch);
  endfunction

  function automatic logic [3:0] read_reg(input logic [2:0] addr);
    logic [3:0] value;
    value = 4'h0;
    if (addr == board_irq_pkg::IDX_SITE_RESET) begin
      value = site_reset_control & SITE_MASK;
    end else if (addr >= board_irq_pkg::IDX_SEL_BASE && addr <= board_irq_pkg::IDX_SEL_LAST) begin
      for (int i = 0; i < board_irq_pkg::NUM_CH; i++) begin
        if (sel_hit(addr, i)) begin
          value = source_select[i] & sel_mask(i);
        end
      end
    end
    return value;
  endfunction

  // site reset register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      site_reset_control <= board_irq_pkg::SITE_RESET_INIT;
    end else if (wr && link.link_addr == board_irq_pkg::IDX_SITE_RESET) begin
      site_reset_control <= link.link_wdata & SITE_MASK;
    end
  end

  // reset pins copy the bits one cycle later through a flop: 0 holds the site in reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      parallel_site_reset_n <= 1'b0;
    end else begin
      parallel_site_reset_n <= site_reset_control[board_irq_pkg::BIT_PARALLEL_RESET];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_sites_reset_n <= 1'b0;
    end else begin
      serial_sites_reset_n <= site_reset_control[board_irq_pkg::BIT_SERIAL_RESET];
    end
  end

  // bit is masked on first gen, so that pin never leaves reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      extender_reset_n <= 1'b0;
    end else begin
      extender_reset_n <= site_reset_control[board_irq_pkg::BIT_EXTENDER_RESET];
    end
  end

  // source selectors
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < board_irq_pkg::NUM_CH; i++) begin
        source_select[i] <= board_irq_pkg::SEL_INIT[i];
      end
    end else if (wr) begin
      for (int i = 0; i < board_irq_pkg::NUM_CH; i++) begin
        if (sel_hit(link.link_addr, i)) begin
          source_select[i] <= (source_select[i] & ~sel_mask(i)) |
                              (link.link_wdata & sel_mask(i));
        end
      end
    end
  end

  // link answer one cycle after each request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.link_ack <= 1'b0;
    end else begin
      link.link_ack <= link.link_req;
    end
  end

  // read data is the value before the write of the same request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.link_rdata <= 4'h0;
    end else if (link.link_req) begin
      link.link_rdata <= read_reg(link.link_addr);
    end
  end

  // source vectors, all normalised to active high
  always_comb begin
    src_later = 16'h0000;
    src_later[board_irq_pkg::CODE_SHARED2] = serial_site_request[2];
    src_later[board_irq_pkg::CODE_SERIAL_CTRL] = ~serial_ctrl_irq_n;
    src_later[board_irq_pkg::CODE_USB] = ~usb_ctrl_irq_n;
    src_later[board_irq_pkg::CODE_SERIAL_SITE0] = serial_site_request[0];
    src_later[board_irq_pkg::CODE_SERIAL_SITE1] = serial_site_request[1];
    src_later[board_irq_pkg::CODE_PARALLEL0] = parallel_site_request[0];
    src_later[board_irq_pkg::CODE_PARALLEL1] = parallel_site_request[1];
    src_later[board_irq_pkg::CODE_PARALLEL2] = parallel_site_request[2];
    src_later[board_irq_pkg::CODE_PARALLEL3] = parallel_site_request[3];
    src_later[board_irq_pkg::CODE_WATCHDOG] = watchdog_expiry_request;
    // clock chip only fitted on the newest boards
    src_later[board_irq_pkg::CODE_CLOCK_WDT] = NEWEST & ~clock_chip_out_first_n;
    src_later[board_irq_pkg::CODE_CLOCK_ALARM] = NEWEST & ~clock_chip_out_second_n;
    src_first = {~usb_ctrl_irq_n, ~serial_ctrl_irq_n, 1'b0, shared_request[2]};
  end

  generate
    for (genvar ch = 0; ch < board_irq_pkg::NUM_CH; ch++) begin : g_ch
      localparam logic IDLE = FIRST && (ch != board_irq_pkg::CH_NMI);
      if (FIRST && ch == board_irq_pkg::CH_NMI) begin : g_nmi_off
        assign route[ch] = 1'b0;
      end else if (FIRST && ch == board_irq_pkg::CH_FOUR) begin : g_four
        assign route[ch] = shared_request[0];
      end else if (FIRST && ch == board_irq_pkg::CH_FIVE) begin : g_five
        assign route[ch] = shared_request[1];
      end else if (FIRST) begin : g_first_sel
        assign route[ch] = pick({2'h0, source_select[ch][1:0]}, {12'h000, src_first});
      end else begin : g_later_sel
        assign route[ch] = pick(source_select[ch], src_later);
      end
      // first gen ext pins idle high; first gen nmi and all later pins idle low
      irq_hold #(
        .IDLE_LEVEL(IDLE)
      ) u_hold (
        .hclk(hclk),
        .hresetn(hresetn),
        .request(route[ch]),
        .pin(irq_pin[ch])
      );
    end
  endgenerate

  assign link.dsp_nmi = irq_pin[0];
  assign link.dsp_ext_irq_four = irq_pin[1];
  assign link.dsp_ext_irq_five = irq_pin[2];
  assign link.dsp_ext_irq_six = irq_pin[3];
  assign link.dsp_ext_irq_seven = irq_pin[4];
endmodule

// ===== logic/dsp_irq_host.sv
module dsp_irq_host (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  board_link_if.dsp link
);
  board_irq_pkg::link_state_e state;
  logic dphase;
  logic [7:0] d_addr;
  logic d_write;
  logic wr_cmd;
  logic [3:0] last_rdata;
  logic [3:0] polarity;
  logic [4:0] irq_mask;
  logic [4:0] irq_status;
  logic [4:0] seen;
  logic [4:0] level;
  logic [4:0] level_q;
  logic [4:0] raw;
  logic [4:0] active_raw;
  logic [4:0] event_set;
  logic [4:0] w1c;
  logic [4:0] next_status;

  function automatic logic wr_at(input logic [7:0] a);
    return dphase & d_write & (d_addr == a);
  endfunction

  assign raw = {link.dsp_ext_irq_seven, link.dsp_ext_irq_six, link.dsp_ext_irq_five,
                link.dsp_ext_irq_four, link.dsp_nmi};
  // polarity bit 1 means the input is active low; nmi is always high
  assign active_raw = raw ^ {polarity, 1'b0};
  assign event_set = level & ~level_q;
  assign w1c = wr_at(board_irq_pkg::ADDR_IRQ_STATUS) ? hwdata[4:0] : 5'h00;
  // set beats clear in the same cycle
  assign next_status = (irq_status & ~w1c) | event_set;
  assign wr_cmd = wr_at(board_irq_pkg::ADDR_LINK_CMD);

  // one wait state so that hrdata comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dphase <= 1'b0;
      d_addr <= 8'h00;
      d_write <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= board_irq_pkg::HRESP_OKAY;
    end else if (hsel && hready && htrans == board_irq_pkg::HTRANS_NONSEQ) begin
      dphase <= 1'b1;
      d_addr <= haddr[7:0];
      d_write <= hwrite;
      hreadyout <= 1'b0;
    end else begin
      dphase <= 1'b0;
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (dphase && !d_write) begin
      case (d_addr)
        board_irq_pkg::ADDR_LINK_STATUS: begin
          hrdata <= {23'h000000, state != board_irq_pkg::LINK_IDLE, 4'h0, last_rdata};
        end
        board_irq_pkg::ADDR_IRQ_STATUS: hrdata <= {27'h0000000, irq_status};
        board_irq_pkg::ADDR_IRQ_MASK: hrdata <= {27'h0000000, irq_mask};
        board_irq_pkg::ADDR_POLARITY: hrdata <= {28'h0000000, polarity};
        board_irq_pkg::ADDR_LEVEL: hrdata <= {27'h0000000, level};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // link command sequencer; commands while busy are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= board_irq_pkg::LINK_IDLE;
      link.link_req <= 1'b0;
      link.link_write <= 1'b0;
      link.link_addr <= 3'h0;
      link.link_wdata <= 4'h0;
      last_rdata <= 4'h0;
    end else begin
      case (state)
        board_irq_pkg::LINK_IDLE: begin
          if (wr_cmd) begin
            link.link_req <= 1'b1;
            link.link_addr <= hwdata[board_irq_pkg::CMD_ADDR_LSB +: 3];
            link.link_wdata <= hwdata[board_irq_pkg::CMD_DATA_LSB +: 4];
            link.link_write <= hwdata[board_irq_pkg::CMD_WRITE_BIT];
            state <= board_irq_pkg::LINK_ISSUE;
          end
        end
        board_irq_pkg::LINK_ISSUE: begin
          link.link_req <= 1'b0;
          state <= board_irq_pkg::LINK_WAIT;
        end
        board_irq_pkg::LINK_WAIT: begin
          if (link.link_ack) begin
            last_rdata <= link.link_rdata;
            state <= board_irq_pkg::LINK_IDLE;
          end
        end
        default: begin
          link.link_req <= 1'b0;
          state <= board_irq_pkg::LINK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      polarity <= board_irq_pkg::POLARITY_INIT;
      irq_mask <= board_irq_pkg::IRQ_INIT;
    end else begin
      if (wr_at(board_irq_pkg::ADDR_POLARITY)) begin
        polarity <= hwdata[3:0];
      end
      if (wr_at(board_irq_pkg::ADDR_IRQ_MASK)) begin
        irq_mask <= hwdata[4:0];
      end
    end
  end

  // two matching samples qualify a request, relying on the board hold
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen <= board_irq_pkg::IRQ_INIT;
      level <= board_irq_pkg::IRQ_INIT;
      level_q <= board_irq_pkg::IRQ_INIT;
    end else begin
      seen <= active_raw;
      level <= active_raw & seen;
      level_q <= level;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= board_irq_pkg::IRQ_INIT;
      irq <= 1'b0;
    end else begin
      irq_status <= next_status;
      irq <= |(next_status & irq_mask);
    end
  end
endmodule

// ===== dv/board_irq_assertions.sv
module board_irq_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic link_req,
  input wire logic link_write,
  input wire logic [2:0] link_addr,
  input wire logic [3:0] link_wdata,
  input wire logic link_ack,
  input wire logic [3:0] link_rdata,
  input wire logic dsp_nmi,
  input wire logic dsp_ext_irq_four,
  input wire logic dsp_ext_irq_five,
  input wire logic dsp_ext_irq_six,
  input wire logic dsp_ext_irq_seven
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // nmi selector resets to no source, so the pin stays idle until software touches it
  logic nmi_touched;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmi_touched <= 1'b0;
    end else if (link_req && link_write && link_addr == board_irq_pkg::IDX_SEL_BASE) begin
      nmi_touched <= 1'b1;
    end
  end

  sequence issued;
    link_req;
  endsequence

  sequence held_two(logic s);
    s [*2];
  endsequence

  property min_hold(logic p);
    $rose(p) |=> held_two(p);
  endproperty

  ack_follow_a:
    assert property (issued |=> link_ack) else $error("link ack missing after request");
  ack_cause_a:
    assert property (link_ack |-> $past(link_req)) else $error("link ack without request");
  nmi_gate_a:
    assert property (!nmi_touched |-> !dsp_nmi) else $error("nmi active from reset selector");
  nmi_hold_a:
    assert property (min_hold(dsp_nmi)) else $error("nmi request too short");
  four_hold_a:
    assert property ($rose(dsp_ext_irq_four) |-> ##1 dsp_ext_irq_four ##1 dsp_ext_irq_four)
      else $error("irq four request too short");
  five_hold_a:
    assert property (min_hold(dsp_ext_irq_five)) else $error("irq five request too short");
  six_hold_a:
    assert property ($rose(dsp_ext_irq_six) |=> $stable(dsp_ext_irq_six) [*2])
      else $error("irq six request too short");
  seven_hold_a:
    assert property ($fell(dsp_ext_irq_seven) |-> $past(dsp_ext_irq_seven, 3))
      else $error("irq seven request too short");
endmodule

// ===== dv/board_irq_router_site_reset_tb_top.sv
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end

module board_irq_router_site_reset_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic hclk;
  logic hresetn;
  logic hsel;
  logic hwrite;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  wire logic hready;
  wire logic irq;
  wire logic [31:0] hrdata;
  logic [2:0] shared_request;
  logic [2:0] serial_site_request;
  logic [3:0] parallel_site_request;
  logic serial_ctrl_irq_n;
  logic usb_ctrl_irq_n;
  logic watchdog_expiry_request;
  logic clock_chip_out_first_n;
  logic clock_chip_out_second_n;
  wire logic parallel_site_reset_n;
  wire logic serial_sites_reset_n;
  wire logic extender_reset_n;
  int errors;
  int n_compared;

  board_link_if board_link();
  board_link_if board_link_first();

  wire logic [4:0] pins = {board_link.dsp_ext_irq_seven, board_link.dsp_ext_irq_six,
    board_link.dsp_ext_irq_five, board_link.dsp_ext_irq_four, board_link.dsp_nmi};
  wire logic [4:0] first_pins = {board_link_first.dsp_ext_irq_seven,
    board_link_first.dsp_ext_irq_six, board_link_first.dsp_ext_irq_five,
    board_link_first.dsp_ext_irq_four, board_link_first.dsp_nmi};

  dsp_irq_host u_dsp_irq_host (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout(hready), .hresp(), .hrdata, .irq, .link(board_link.dsp));

  board_irq_router_site_reset #(.BOARD_VARIANT(board_irq_pkg::VARIANT_NEWEST))
    u_board_irq_router_site_reset (.hclk, .hresetn, .link(board_link.board), .shared_request,
    .serial_site_request, .parallel_site_request, .serial_ctrl_irq_n, .usb_ctrl_irq_n,
    .watchdog_expiry_request, .clock_chip_out_first_n, .clock_chip_out_second_n,
    .parallel_site_reset_n, .serial_sites_reset_n, .extender_reset_n);

  board_irq_router_site_reset #(.BOARD_VARIANT(board_irq_pkg::VARIANT_FIRST))
    u_board_irq_router_site_reset_first (.hclk, .hresetn, .link(board_link_first.board),
    .shared_request, .serial_site_request, .parallel_site_request, .serial_ctrl_irq_n,
    .usb_ctrl_irq_n, .watchdog_expiry_request, .clock_chip_out_first_n,
    .clock_chip_out_second_n, .parallel_site_reset_n(), .serial_sites_reset_n(),
    .extender_reset_n());

  board_irq_assertions u_board_irq_assertions (.hclk, .hresetn,
    .link_req(board_link.link_req), .link_write(board_link.link_write),
    .link_addr(board_link.link_addr), .link_wdata(board_link.link_wdata),
    .link_ack(board_link.link_ack), .link_rdata(board_link.link_rdata),
    .dsp_nmi(board_link.dsp_nmi), .dsp_ext_irq_four(board_link.dsp_ext_irq_four),
    .dsp_ext_irq_five(board_link.dsp_ext_irq_five), .dsp_ext_irq_six(board_link.dsp_ext_irq_six),
    .dsp_ext_irq_seven(board_link.dsp_ext_irq_seven));

  always #20 hclk = ~hclk;

  task automatic results();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge hclk);
  endtask

  // no fixed latency assumed: wait for hready in both phases
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= board_irq_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50) begin
      errors++;
      results();
    end
  endtask

  task automatic link_op(input logic [2:0] idx, input logic wr, input logic [3:0] d,
      output logic [3:0] old);
    logic [31:0] r;
    logic [31:0] cmd;
    int n;
    cmd = 32'(idx) | (32'(d) << board_irq_pkg::CMD_DATA_LSB);
    cmd[board_irq_pkg::CMD_WRITE_BIT] = wr;
    ahb(1'b1, board_irq_pkg::ADDR_LINK_CMD, cmd, r);
    n = 0;
    r = 32'h0000_0100;
    while (r[board_irq_pkg::STATUS_BUSY_BIT] !== 1'b0 && n < 20) begin
      ahb(1'b0, board_irq_pkg::ADDR_LINK_STATUS, 32'h0, r);
      n++;
    end
    if (n >= 20) begin
      errors++;
      results();
    end
    old = r[3:0];
  endtask

  // first-gen link has no host here: hold the request until the board acks it
  task automatic first_op(input logic [2:0] idx, input logic wr, input logic [3:0] d,
      output logic [3:0] old);
    int n;
    n = 0;
    board_link_first.link_req <= 1'b1;
    board_link_first.link_write <= wr;
    board_link_first.link_addr <= idx;
    board_link_first.link_wdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (board_link_first.link_ack !== 1'b1 && n < 8);
    board_link_first.link_req <= 1'b0;
    old = board_link_first.link_rdata;
    @(posedge hclk);
    if (n >= 8) begin
      errors++;
      results();
    end
  endtask

  task automatic src(input logic [3:0] c, input logic on, input logic all);
    shared_request <= {3{all}};
    serial_site_request <= {3{all}} | (on ? {c == 4'h0, c == 4'h5, c == 4'h4} : 3'h0);
    parallel_site_request <= {4{all}} | ((on && c[3:2] == 2'b10) ? 4'h1 << c[1:0] : 4'h0);
    serial_ctrl_irq_n <= !(all || (on && c == 4'h2));
    usb_ctrl_irq_n <= !(all || (on && c == 4'h3));
    watchdog_expiry_request <= all || (on && c == 4'hC);
    clock_chip_out_first_n <= !(all || (on && c == 4'hD));
    clock_chip_out_second_n <= !(all || (on && c == 4'hE));
  endtask

  task automatic t_reset();
    logic [3:0] old;
    logic [31:0] r;
    `CHK({extender_reset_n, serial_sites_reset_n, parallel_site_reset_n}, 3'h0)
    `CHK(pins, 5'h00)
    `CHK(first_pins, 5'h1E)
    for (int ch = 0; ch < board_irq_pkg::NUM_CH; ch++) begin
      link_op(board_irq_pkg::IDX_SEL_BASE + 3'(ch), 1'b0, 4'h0, old);
      `CHK(old, board_irq_pkg::SEL_INIT[ch])
    end
    link_op(3'h6, 1'b0, 4'h0, old);
    `CHK(old, 4'h0)
    ahb(1'b0, 8'h20, 32'h0, r);
    `CHK(r, 32'h0)
  endtask

  task automatic t_site();
    logic [3:0] old;
    link_op(board_irq_pkg::IDX_SITE_RESET, 1'b1, 4'hF, old);
    `CHK(old, 4'h0)
    link_op(board_irq_pkg::IDX_SITE_RESET, 1'b1, 4'h2, old);
    `CHK(old, 4'h7)
    `CHK({extender_reset_n, serial_sites_reset_n, parallel_site_reset_n}, 3'h2)
  endtask

  // every code on a rotating channel; reserved codes face all sources at once
  task automatic t_route();
    logic [3:0] old;
    logic ok;
    int ch;
    for (int c = 0; c < 16; c++) begin
      ch = c % 5;
      ok = c inside {0, 2, 3, 4, 5, [8:14]};
      link_op(board_irq_pkg::IDX_SEL_BASE + 3'(ch), 1'b1, 4'(c), old);
      src(4'(c), ok, !ok);
      cyc(3);
      `CHK(pins[ch], ok)
      src(4'h0, 1'b0, 1'b0);
      cyc(5);
      `CHK(pins[ch], 1'b0)
    end
  endtask

  task automatic t_hold_irq();
    logic [31:0] r;
    int cnt;
    cnt = 0;
    ahb(1'b1, board_irq_pkg::ADDR_IRQ_STATUS, 32'h1F, r);
    src(4'hB, 1'b1, 1'b0);
    cyc(1);
    src(4'h0, 1'b0, 1'b0);
    repeat (8) begin
      @(posedge hclk);
      cnt += int'(pins[board_irq_pkg::CH_FOUR] === 1'b1);
    end
    `CHK(cnt, 3)
    ahb(1'b0, board_irq_pkg::ADDR_IRQ_STATUS, 32'h0, r);
    `CHK(r[4:0], 5'(1 << board_irq_pkg::CH_FOUR))
    `CHK(irq, 1'b0)
    ahb(1'b1, board_irq_pkg::ADDR_IRQ_MASK, 32'(1 << board_irq_pkg::CH_FOUR), r);
    cyc(2);
    `CHK(irq, 1'b1)
    ahb(1'b1, board_irq_pkg::ADDR_IRQ_STATUS, 32'(1 << board_irq_pkg::CH_FOUR), r);
    cyc(2);
    `CHK(irq, 1'b0)
    ahb(1'b1, board_irq_pkg::ADDR_POLARITY, 32'h0000000F, r);
    cyc(3);
    ahb(1'b0, board_irq_pkg::ADDR_LEVEL, 32'h0, r);
    `CHK(r[4:0], 5'h1E)
    ahb(1'b1, board_irq_pkg::ADDR_POLARITY, 32'h0, r);
  endtask

  task automatic t_first();
    logic [3:0] old;
    for (int i = 0; i < 4; i++) begin
      shared_request <= (i < 3) ? 3'(1 << i) : 3'h0;
      serial_ctrl_irq_n <= (i != 3);
      cyc(3);
      `CHK(first_pins, 5'h1E & ~5'(2 << i))
      shared_request <= 3'h0;
      serial_ctrl_irq_n <= 1'b1;
      cyc(5);
      `CHK(first_pins, 5'h1E)
    end
    first_op(board_irq_pkg::IDX_SITE_RESET, 1'b1, 4'hF, old);
    first_op(board_irq_pkg::IDX_SITE_RESET, 1'b0, 4'h0, old);
    `CHK(old, 4'h3)
    first_op(board_irq_pkg::IDX_SEL_LAST, 1'b1, 4'hF, old);
    `CHK(old, 4'h2)
    usb_ctrl_irq_n <= 1'b0;
    cyc(3);
    `CHK(first_pins, 5'h0E)
    usb_ctrl_irq_n <= 1'b1;
  endtask

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    board_link_first.link_req = 1'b0;
    errors = 0;
    n_compared = 0;
    src(4'h0, 1'b0, 1'b0);
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_site();
    t_route();
    t_hold_irq();
    t_first();
    results();
  end
endmodule
